// >>> src/pbs_defines.svh
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
`define PBS_DIV_W        24
`define PBS_ADDR_W       16
`define PBS_DATA_W       16
`define PBS_STATIC_W     8
`define PBS_LAT_STIM     13
`define PBS_LAT_CAPT     10
`define PBS_MIN_LOOP     3
`define PBS_DIV_RESET    24'h000001
`endif

// >>> src/pbs_pkg.sv
package pbs_pkg;
  typedef enum logic [2:0] {
    PBS_TRIG_NONE       = 3'h0,
    PBS_TRIG_LEVEL      = 3'h1,
    PBS_TRIG_LEVEL_FREE = 3'h2,
    PBS_TRIG_EDGE       = 3'h3,
    PBS_TRIG_EDGE_FREE  = 3'h4
  } pbs_mode_type;
  typedef enum logic [1:0] {
    PBS_IDLE = 2'h0,
    PBS_WAIT = 2'h1,
    PBS_LAT  = 2'h2,
    PBS_RUN  = 2'h3
  } pbs_state_type;
  typedef enum logic [2:0] {
    PBS_CMD_NONE  = 3'h0,
    PBS_CMD_SETA  = 3'h1,
    PBS_CMD_READ  = 3'h2,
    PBS_CMD_WRITE = 3'h3,
    PBS_CMD_RDA   = 3'h4,
    PBS_CMD_WRA   = 3'h5
  } pbs_cmd_type;
  typedef struct packed {
    pbs_cmd_type  op;
    logic [15:0]  addr;
    logic [15:0]  data;
  } pbs_req_type;
  typedef struct packed {
    logic [15:0] first;
    logic [15:0] last;
    logic [15:0] reload;
  } pbs_loop_type;
endpackage

// >>> src/pbs_pattern_bit_sequencer.sv
// Overview of operation
// - 24-bit step divider, divide 1 to 16777216
// - divider input at most 100MHz, predivided
// - host loads and reads address counter
// - counter-addressed read or write then increments
// - dump returns consecutive words from counter
// - burst load stores consecutive words, increments
// - explicit read returns word, counter=addr+1
// - explicit write stores word, counter=addr+1
// - last address reloads counter with reload address
// - measurement entry loads first address, outputs it
// - mode 0 free, 1 level, 3 edge
// - modes 2,4: first loop free then triggered
// - polarity 0 low active, 1 high active
// - start latency 13 stimulus, 10 capture steps
// - held level trigger doubles last step
// - static command drives 8-bit value at once
// - disable flag tri-states the outputs
// - pattern replaces static value during measurement
`include "pbs_defines.svh"
module pbs_pattern_bit_sequencer #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int DATA_W = `PBS_DATA_W
) (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic [`PBS_DIV_W-1:0]      stepDivMinus1,
  input  wire pbs_pkg::pbs_req_type       hostReq,
  output logic      [DATA_W-1:0]          hostRdData,
  output logic                            hostRdValid,
  output logic      [ADDR_W-1:0]          addrCount,
  input  wire pbs_pkg::pbs_loop_type      loopCfg,
  input  wire pbs_pkg::pbs_mode_type      loopTriggerMode,
  input  wire logic                       trigActiveHigh,
  input  wire logic                       captureMode,
  input  wire logic                       measureEn,
  input  wire logic                       staticWr,
  input  wire logic [`PBS_STATIC_W-1:0]   staticValue,
  input  wire logic                       staticDisable,
  input  wire logic                       patTrigIn,
  output logic      [DATA_W-1:0]          patOut,
  output logic      [DATA_W-1:0]          patOutEn,
  output logic                            running
);
  import pbs_pkg::*;

  // host and loop fields are 16 bits wide, so wider counters cannot be served
  if (ADDR_W < 2 || ADDR_W > 16 || DATA_W < `PBS_STATIC_W
      || DATA_W > 16) begin : g_bad_width
    $error("pbs: unsupported width");
  end

  logic [DATA_W-1:0]           mem [0:(1<<ADDR_W)-1];
  logic [`PBS_DIV_W-1:0]       divCnt_r;
  logic                        stepTick_r;
  logic [3:0]                  latCnt_r;
  logic                        trigPrev_r;
  logic                        firstLoop_r;
  logic                        measPrev_r;
  pbs_state_type               state_r;
  logic [ADDR_W-1:0]           reqAddr;
  logic                        trigAct;
  logic                        trigEdge;
  logic                        needTrig;
  logic                        trigOk;
  logic                        hostAcc;
  logic                        atLast;

  assign reqAddr  = hostReq.addr[ADDR_W-1:0];
  assign trigAct  = trigActiveHigh ? patTrigIn : ~patTrigIn;
  assign trigEdge = trigAct & ~trigPrev_r;
  assign hostAcc  = (state_r == PBS_IDLE) && !measureEn;
  assign atLast   = (addrCount == loopCfg.last[ADDR_W-1:0]);

  // trigger requirement per loop
  always_comb begin
    needTrig = 1'b0;
    trigOk   = 1'b0;
    case (loopTriggerMode)
      PBS_TRIG_NONE: begin
        needTrig = 1'b0;
        trigOk   = 1'b1;
      end
      PBS_TRIG_LEVEL: begin
        needTrig = 1'b1;
        trigOk   = trigAct;
      end
      PBS_TRIG_EDGE: begin
        needTrig = 1'b1;
        trigOk   = trigEdge;
      end
      PBS_TRIG_LEVEL_FREE: begin
        needTrig = ~firstLoop_r;
        trigOk   = trigAct;
      end
      PBS_TRIG_EDGE_FREE: begin
        needTrig = ~firstLoop_r;
        trigOk   = trigEdge;
      end
      default: begin
        needTrig = 1'b0;
        trigOk   = 1'b1;
      end
    endcase
  end

  // step divider, input assumed predivided to at most 100MHz
  always_ff @(posedge sys_clk) begin
    if (srst || divCnt_r == '0) begin
      divCnt_r <= stepDivMinus1;
    end else begin
      divCnt_r <= divCnt_r - `PBS_DIV_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stepTick_r <= 1'b0;
    end else begin
      stepTick_r <= (divCnt_r == '0);
    end
  end

  // trigger sampled on step ticks only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trigPrev_r <= 1'b1;
      measPrev_r <= 1'b0;
    end else begin
      if (stepTick_r)
        trigPrev_r <= trigAct;
      measPrev_r <= measureEn;
    end
  end

  // sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r     <= PBS_IDLE;
      latCnt_r    <= 4'h0;
      firstLoop_r <= 1'b1;
    end else if (!measureEn) begin
      state_r     <= PBS_IDLE;
      firstLoop_r <= 1'b1;
    end else begin
      case (state_r)
        PBS_IDLE: begin
          if (!measPrev_r) begin
            state_r     <= PBS_WAIT;
            firstLoop_r <= 1'b1;
          end
        end
        PBS_WAIT: begin
          if (stepTick_r) begin
            if (!needTrig) begin
              state_r <= PBS_RUN;
            end else if (trigOk && firstLoop_r) begin
              state_r  <= PBS_LAT;
              latCnt_r <= captureMode ? 4'(`PBS_LAT_CAPT - 2)
                                      : 4'(`PBS_LAT_STIM - 2);
            end else if (trigOk) begin
              // later loops restart with no start latency
              state_r <= PBS_RUN;
            end
          end
        end
        PBS_LAT: begin
          if (stepTick_r) begin
            if (latCnt_r == 4'h0)
              state_r <= PBS_RUN;
            else
              latCnt_r <= latCnt_r - 4'h1;
          end
        end
        PBS_RUN: begin
          if (stepTick_r && atLast) begin
            firstLoop_r <= 1'b0;
            // triggered modes park on the last step until re-armed,
            // so a held level shows it for two periods
            if (loopTriggerMode != PBS_TRIG_NONE)
              state_r <= PBS_WAIT;
          end
        end
        default: state_r <= PBS_IDLE;
      endcase
    end
  end

  // address counter, memory and host access
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addrCount   <= '0;
      hostRdData  <= '0;
      hostRdValid <= 1'b0;
    end else begin
      hostRdValid <= 1'b0;
      if (measureEn && !measPrev_r) begin
        addrCount <= loopCfg.first[ADDR_W-1:0];
      end else if (state_r == PBS_RUN && stepTick_r) begin
        if (atLast && loopTriggerMode != PBS_TRIG_NONE)
          addrCount <= addrCount;
        else if (atLast)
          addrCount <= loopCfg.reload[ADDR_W-1:0];
        else
          addrCount <= addrCount + ADDR_W'(1);
      end else if (state_r == PBS_WAIT && stepTick_r && !firstLoop_r
                   && (!needTrig || trigOk)) begin
        addrCount <= loopCfg.reload[ADDR_W-1:0];
      end else if (hostAcc) begin
        case (hostReq.op)
          PBS_CMD_SETA: addrCount <= reqAddr;
          PBS_CMD_READ: begin
            hostRdData  <= mem[addrCount];
            hostRdValid <= 1'b1;
            addrCount   <= addrCount + ADDR_W'(1);
          end
          PBS_CMD_WRITE: addrCount <= addrCount + ADDR_W'(1);
          PBS_CMD_RDA: begin
            hostRdData  <= mem[reqAddr];
            hostRdValid <= 1'b1;
            addrCount   <= reqAddr + ADDR_W'(1);
          end
          PBS_CMD_WRA: addrCount <= reqAddr + ADDR_W'(1);
          default: addrCount <= addrCount;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hostAcc && hostReq.op == PBS_CMD_WRITE)
      mem[addrCount] <= hostReq.data[DATA_W-1:0];
    else if (hostAcc && hostReq.op == PBS_CMD_WRA)
      mem[reqAddr] <= hostReq.data[DATA_W-1:0];
  end

  // output drive
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      patOut   <= '0;
      patOutEn <= '0;
      running  <= 1'b0;
    end else begin
      running <= measureEn && state_r != PBS_IDLE;
      if (measureEn && state_r != PBS_IDLE) begin
        patOut   <= mem[addrCount];
        patOutEn <= '1;
      end else if (staticWr) begin
        patOut   <= DATA_W'(staticValue);
        patOutEn <= staticDisable ? '0 : '1;
      end
    end
  end

  a_last_reload: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_RUN && stepTick_r && atLast
     && measureEn && measPrev_r && loopTriggerMode == PBS_TRIG_NONE)
    |=> addrCount == $past(loopCfg.reload[ADDR_W-1:0]))
    else $error("counter did not reload at last address");
  a_last_hold: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_RUN && stepTick_r && atLast
     && measureEn && measPrev_r && loopTriggerMode != PBS_TRIG_NONE)
    |=> addrCount == $past(addrCount) && state_r == PBS_WAIT)
    else $error("last step not held for re-arm");
  a_rearm_reload: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_WAIT && stepTick_r && !firstLoop_r
     && needTrig && trigOk && measureEn && measPrev_r)
    |=> state_r == PBS_RUN && addrCount == $past(loopCfg.reload[ADDR_W-1:0]))
    else $error("re-armed loop did not restart at reload");
  a_entry_first: assert property (@(posedge sys_clk)
    disable iff (srst) $rose(measureEn)
    |=> addrCount == $past(loopCfg.first[ADDR_W-1:0]))
    else $error("counter not loaded with first address");
  a_rda_incr: assert property (@(posedge sys_clk)
    disable iff (srst) (hostAcc && hostReq.op == PBS_CMD_RDA && !measureEn)
    |=> hostRdValid && addrCount == $past(reqAddr) + ADDR_W'(1))
    else $error("explicit read did not set counter");
  a_wra_incr: assert property (@(posedge sys_clk)
    disable iff (srst) (hostAcc && hostReq.op == PBS_CMD_WRA && !measureEn)
    |=> addrCount == $past(reqAddr) + ADDR_W'(1))
    else $error("explicit write did not set counter");
  a_seta_load: assert property (@(posedge sys_clk)
    disable iff (srst) (hostAcc && hostReq.op == PBS_CMD_SETA && !measureEn)
    |=> addrCount == $past(reqAddr))
    else $error("counter load failed");
  a_read_incr: assert property (@(posedge sys_clk)
    disable iff (srst) (hostAcc && hostReq.op == PBS_CMD_READ && !measureEn)
    |=> hostRdValid && addrCount == $past(addrCount) + ADDR_W'(1))
    else $error("counter read did not advance");
  a_static_drive: assert property (@(posedge sys_clk)
    disable iff (srst) (staticWr && !measureEn)
    |=> patOut == DATA_W'($past(staticValue))
        && patOutEn == ($past(staticDisable) ? '0 : '1))
    else $error("static output not applied");
  a_run_step: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_RUN && stepTick_r && !atLast
     && measureEn && measPrev_r)
    |=> addrCount == $past(addrCount) + ADDR_W'(1))
    else $error("counter did not step");
  a_no_trig_wait: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_WAIT && stepTick_r && !trigAct
     && loopTriggerMode == PBS_TRIG_LEVEL && measureEn)
    |=> state_r == PBS_WAIT)
    else $error("loop started without trigger");
  a_mode2_first: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_WAIT && stepTick_r && firstLoop_r
     && measureEn && loopTriggerMode == PBS_TRIG_LEVEL_FREE)
    |=> state_r == PBS_RUN)
    else $error("first free loop waited");
  a_lat_enter: assert property (@(posedge sys_clk)
    disable iff (srst) (state_r == PBS_WAIT && stepTick_r && needTrig
     && trigOk && firstLoop_r && measureEn)
    |=> state_r == PBS_LAT)
    else $error("latency not entered");

  c_run: cover property (@(posedge sys_clk) state_r == PBS_RUN && atLast);
  c_lat: cover property (@(posedge sys_clk) state_r == PBS_LAT);
  c_rd: cover property (@(posedge sys_clk) hostRdValid);
  c_rearm: cover property (@(posedge sys_clk)
    state_r == PBS_WAIT && stepTick_r && !firstLoop_r && trigOk);
endmodule

// >>> bench/pbs_trig_src.sv
module pbs_trig_src (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       activeHigh,
  input  wire logic       fire,
  input  wire logic [7:0] len,
  output logic            trig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  // one pulse of len cycles, then back to the idle level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= 8'h00;
    end else if (fire) begin
      cnt_r <= len;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign trig = (cnt_r != 8'h00) ? activeHigh : ~activeHigh;
endmodule

// >>> bench/pbs_pattern_bit_sequencer_tb.sv
module pbs_pattern_bit_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pbs_pkg::*;
  logic         sys_clk = 1'b0;
  logic         srst = 1'b1;
  logic [23:0]  stepDivMinus1 = 24'h000000;
  pbs_req_type  hostReq = '{PBS_CMD_NONE, 16'h0000, 16'h0000};
  pbs_loop_type loopCfg = '{16'h000a, 16'h000d, 16'h000b};
  pbs_mode_type loopTriggerMode = PBS_TRIG_NONE;
  logic [15:0]  hostRdData, addrCount, patOut, patOutEn, a;
  logic         hostRdValid, running, patTrigIn;
  logic         trigActiveHigh = 1'b1, captureMode = 1'b0;
  logic         measureEn = 1'b0, staticWr = 1'b0, staticDisable = 1'b0;
  logic         fire = 1'b0;
  logic [7:0]   staticValue = 8'h00, len = 8'h02;
  logic [15:0]  pat [0:3] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  int           nFail = 0, testsRun = 0, k, gap;

  always #50 sys_clk = ~sys_clk;

  pbs_pattern_bit_sequencer uut (.sys_clk, .srst, .stepDivMinus1, .hostReq,
    .hostRdData, .hostRdValid, .addrCount, .loopCfg, .loopTriggerMode,
    .trigActiveHigh, .captureMode, .measureEn, .staticWr, .staticValue,
    .staticDisable, .patTrigIn, .patOut, .patOutEn, .running);

  pbs_trig_src trig_src (.sys_clk, .srst, .activeHigh(trigActiveHigh),
    .fire, .len, .trig(patTrigIn));

  task automatic tally_and_finish;
    if (nFail == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // request held one cycle; back to back calls keep it up
  task automatic cmd(input pbs_cmd_type op, input logic [15:0] ad, dt);
    hostReq = '{op, ad, dt};
    cyc(1);
  endtask

  task automatic idle;
    hostReq = '{PBS_CMD_NONE, 16'h0000, 16'h0000};
    cyc(1);
  endtask

  task automatic rdchk(input pbs_cmd_type op, input logic [15:0] ad, exp);
    cmd(op, ad, 16'h0000);
    chk("hostRdValid", 24'h1, hostRdValid);
    chk("hostRdData", exp, hostRdData);
  endtask

  task automatic stat(input logic [7:0] v, input logic dis);
    staticValue = v;
    staticDisable = dis;
    staticWr = 1'b1;
    cyc(1);
    staticWr = 1'b0;
    if (!dis) chk("patOut", {8'h00, v}, patOut);
    chk("patOutEn", dis ? 16'h0000 : 16'hffff, patOutEn);
    cyc(1);
  endtask

  // cycles until the counter leaves the first address
  task automatic wait_move;
    k = 0;
    while (addrCount === 16'h000a) begin
      cyc(1);
      k++;
      if (k == 40) begin
        nFail++;
        tally_and_finish();
      end
    end
  endtask

  initial begin
    cyc(5);
    srst = 1'b0;
    cyc(1);
    chk("patOutEn", 16'h0000, patOutEn);
    chk("running", 24'h0, running);
    cmd(PBS_CMD_WRA, 16'h000a, pat[0]);
    chk("addrCount", 16'h000b, addrCount);
    for (int i = 1; i < 4; i++) cmd(PBS_CMD_WRITE, 16'h0000, pat[i]);
    idle();
    chk("addrCount", 16'h000e, addrCount);
    cmd(PBS_CMD_SETA, 16'h0005, 16'h0000);
    chk("addrCount", 16'h0005, addrCount);
    cmd(PBS_CMD_WRITE, 16'h0000, 16'h00ff);
    chk("addrCount", 16'h0006, addrCount);
    rdchk(PBS_CMD_RDA, 16'h0005, 16'h00ff);
    chk("addrCount", 16'h0006, addrCount);
    cmd(PBS_CMD_SETA, 16'h000a, 16'h0000);
    for (int i = 0; i < 4; i++) rdchk(PBS_CMD_READ, 16'h0000, pat[i]);
    idle();
    chk("addrCount", 16'h000e, addrCount);
    stat(8'h5a, 1'b0);
    stat(8'hff, 1'b1);
    stat(8'h00, 1'b0);
    stepDivMinus1 = 24'h000002;
    measureEn = 1'b1;
    cyc(1);
    chk("addrCount", 16'h000a, addrCount);
    gap = -1;
    k = 0;
    repeat (40) begin
      a = addrCount;
      cyc(1);
      k++;
      chk("running", 24'h1, running);
      // the output word trails the counter by one clock
      chk("patOut", pat[a[1:0] - 2'h2], patOut);
      if (addrCount !== a) begin
        if (gap >= 0) chk("stepGap", 24'd3, k);
        chk("addrCount", a == 16'h000d ? 16'h000b : a + 16'h0001,
            addrCount);
        gap = k;
        k = 0;
      end
    end
    measureEn = 1'b0;
    stepDivMinus1 = 24'h000000;
    cyc(3);
    for (int m = 1; m < 5; m++) begin
      loopTriggerMode = pbs_mode_type'(m);
      trigActiveHigh = (m > 2);
      captureMode = (m == 1);
      cyc(2);
      measureEn = 1'b1;
      cyc(1);
      if (m == 1 || m == 3) begin
        cyc(20);
        chk("addrCount", 16'h000a, addrCount);
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        wait_move();
        chk("latency", 24'h1, captureMode ? (k >= 10 && k <= 12)
            : (k >= 13 && k <= 15));
      end else begin
        wait_move();
        chk("freeStart", 24'h1, k <= 4);
      end
      cyc(30);
      a = addrCount;
      cyc(10);
      chk("addrCount", a, addrCount);
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
      cyc(1);
      chk("addrCount", 16'h000b, addrCount);
      measureEn = 1'b0;
      cyc(3);
    end
    tally_and_finish();
  end
endmodule
